// ==== epg_board.sv ====
// board model: pullups and external sources on the eight pins
`default_nettype none
module epg_board (
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // pin levels
    // device pull-down wins, then the board source, else the pullup
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_level[i] = pin_oe[i] ? 1'b0 : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule : epg_board
`default_nettype wire

// ==== epg_consts.svh ====
// constants for the eight pin gpio port
`ifndef EPG_CONSTS_SVH
`define EPG_CONSTS_SVH
`define EPG_DATA_OFFSET 8'h7a
`define EPG_CFG_OFFSET 8'h12
`define EPG_DATA_RESET 8'hff
`define EPG_CFG_RESET 4'h0
`define EPG_PIN_FAULT_IN 0
`define EPG_PIN_FAULT_OUT 1
`define EPG_PIN_TRIG_IN 2
`define EPG_PIN_READY 3
`endif

// ==== epg_gpio_port.sv ====
// eight pin gpio port with four alternate functions
`include "epg_consts.svh"
`default_nettype none
// Overview of operation
// - eight pins; pins 0-3 select alternate function via config register, 4-7 plain
// - alternates: pin0 fault input, pin1 alarm out, pin2 trigger, pin3 data ready
// - a plain gpio pin acting as output follows its data register bit
// - data register read returns the live pin level for input pins
// - reset sets every data bit to 1, all pins released and pulled up
// - ready pin low after direct conversion; released on new conversion or data access
// - fault input pin is active low
// - alarm pin asserts on any unmasked alarm event
module epg_gpio_port (
    input wire logic ref_clk,
    input wire logic rst,
    // register port from the serial interface
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire epg_pkg::epg_byte_t reg_wdata,
    output epg_pkg::epg_byte_t reg_rdata,
    output logic reg_rvalid,
    // pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    // device core side
    input wire logic alarm_event,
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic adc_data_access,
    output logic fault_input,
    output logic fault_output,
    output logic conversion_trigger_input,
    output logic data_ready_indicator
);
    import epg_pkg::*;

    // ==========================================
    // registers
    epg_byte_t data_q;
    epg_byte_t data_d;
    logic [3:0] cfg_q;
    logic [3:0] cfg_d;
    epg_byte_t rdata_q;
    epg_byte_t rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic ready_q;
    logic ready_d;
    logic alarm_q;
    logic alarm_d;
    epg_byte_t pin_sync;

    // pins are asynchronous to the core clock
    epg_sync #(
        .WIDTH(8)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // ==========================================
    // next state
    always_comb begin
        data_d = data_q;
        cfg_d = cfg_q;
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        ready_d = ready_q;
        alarm_d = alarm_event;
        if (reg_wr && hit(reg_addr, `EPG_DATA_OFFSET)) begin
            data_d = reg_wdata;
        end
        if (reg_wr && hit(reg_addr, `EPG_CFG_OFFSET)) begin
            cfg_d = reg_wdata[3:0];
        end
        if (reg_rd) begin
            rvalid_d = 1'b1;
            if (hit(reg_addr, `EPG_DATA_OFFSET)) begin
                // released bits show the pin level, driven bits the stored 0
                rdata_d = pin_sync & data_q;
            end else if (hit(reg_addr, `EPG_CFG_OFFSET)) begin
                rdata_d = {4'h0, cfg_q};
            end else begin
                rdata_d = 8'h00;
            end
        end
        // set wins so a completion in the release cycle is never lost
        if (conv_start || adc_data_access) begin
            ready_d = 1'b0;
        end
        if (conv_done) begin
            ready_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_q <= `EPG_DATA_RESET;
            cfg_q <= `EPG_CFG_RESET;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
            ready_q <= 1'b0;
            alarm_q <= 1'b0;
        end else begin
            data_q <= data_d;
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            ready_q <= ready_d;
            alarm_q <= alarm_d;
        end
    end

    // ==========================================
    // pin drive
    always_comb begin
        // open drain: the port only ever pulls a pin low
        pin_out = 8'h00;
        pin_oe = ~data_q;
        if (cfg_q[`EPG_PIN_FAULT_IN]) begin
            pin_oe[`EPG_PIN_FAULT_IN] = 1'b0;
        end
        if (cfg_q[`EPG_PIN_FAULT_OUT]) begin
            pin_oe[`EPG_PIN_FAULT_OUT] = alarm_q;
        end
        if (cfg_q[`EPG_PIN_TRIG_IN]) begin
            pin_oe[`EPG_PIN_TRIG_IN] = 1'b0;
        end
        if (cfg_q[`EPG_PIN_READY]) begin
            pin_oe[`EPG_PIN_READY] = ready_q;
        end
    end

    assign fault_input = cfg_q[`EPG_PIN_FAULT_IN] & ~pin_sync[`EPG_PIN_FAULT_IN];
    assign fault_output = cfg_q[`EPG_PIN_FAULT_OUT] & alarm_q;
    assign conversion_trigger_input = cfg_q[`EPG_PIN_TRIG_IN] & pin_sync[`EPG_PIN_TRIG_IN];
    assign data_ready_indicator = cfg_q[`EPG_PIN_READY] & ready_q;
    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;

    // ==========================================
    // checks
    a_data_write: assert property (@(posedge ref_clk) disable iff (rst)
        reg_wr && reg_addr == `EPG_DATA_OFFSET |=> data_q == $past(reg_wdata))
        else $error("data register not written");
    a_drive_low: assert property (@(posedge ref_clk) disable iff (rst)
        !data_q[7] |-> pin_oe[7] && !pin_out[7])
        else $error("pin 7 not driven low");
    a_release_high: assert property (@(posedge ref_clk) disable iff (rst)
        data_q[5] |-> !pin_oe[5])
        else $error("pin 5 not released");
    a_read_pin: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == `EPG_DATA_OFFSET && data_q[6]
        |=> reg_rvalid && reg_rdata[6] == $past(pin_sync[6]))
        else $error("read not showing pin level");
    a_ready_set: assert property (@(posedge ref_clk) disable iff (rst)
        conv_done && !conv_start && !adc_data_access ##1 cfg_q[3] |-> pin_oe[3])
        else $error("ready pin not driven low");
    a_ready_clear: assert property (@(posedge ref_clk) disable iff (rst)
        conv_start && !conv_done |=> !ready_q)
        else $error("ready not released");
    a_fault_low: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_q[0] && !pin_sync[0] |-> fault_input)
        else $error("fault input missed");
    a_alarm_out: assert property (@(posedge ref_clk) disable iff (rst)
        alarm_event && cfg_q[1] ##1 cfg_q[1] |-> pin_oe[1])
        else $error("alarm pin not asserted");
    a_cfg_plain: assert property (@(posedge ref_clk) disable iff (rst)
        pin_oe[7:4] == ~data_q[7:4])
        else $error("upper pins not plain gpio");
    a_reset_ones: assert property (@(posedge ref_clk)
        $fell(rst) |-> data_q == 8'hff)
        else $error("data not all ones after reset");
    // ==========================================
    // checks: access and alternate functions
    a_ready_wins: assert property (@(posedge ref_clk) disable iff (rst)
        conv_done |=> ready_q)
        else $error("completion lost");
    a_ready_access: assert property (@(posedge ref_clk) disable iff (rst)
        adc_data_access && !conv_done |=> !ready_q)
        else $error("ready not released on access");
    a_plain_low: assert property (@(posedge ref_clk) disable iff (rst)
        (pin_oe[3:0] & ~cfg_q) == (~data_q[3:0] & ~cfg_q))
        else $error("lower pins not plain gpio");
    a_cfg_write: assert property (@(posedge ref_clk) disable iff (rst)
        reg_wr && reg_addr == `EPG_CFG_OFFSET |=> cfg_q == $past(reg_wdata[3:0]))
        else $error("config register not written");
    a_rd_unmapped: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr != `EPG_DATA_OFFSET && reg_addr != `EPG_CFG_OFFSET
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rvalid_pulse: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_rvalid_idle: assert property (@(posedge ref_clk) disable iff (rst)
        !reg_rd |=> !reg_rvalid)
        else $error("read valid without read");
    a_read_driven: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == `EPG_DATA_OFFSET && !data_q[4] |=> !reg_rdata[4])
        else $error("driven pin not read low");
    a_out_zero: assert property (@(posedge ref_clk) disable iff (rst)
        pin_out == 8'h00)
        else $error("pin driven high");
    a_fault_none: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_q[0] |-> !pin_oe[0])
        else $error("fault input pin driven");
    a_trig_none: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_q[2] |-> !pin_oe[2] && conversion_trigger_input == pin_sync[2])
        else $error("trigger pin wrong");
    a_alarm_idle: assert property (@(posedge ref_clk) disable iff (rst)
        !alarm_event ##1 cfg_q[1] |-> !pin_oe[1] && !fault_output)
        else $error("alarm pin stuck");
    a_fault_high: assert property (@(posedge ref_clk) disable iff (rst)
        pin_sync[0] |-> !fault_input)
        else $error("fault input on high pin");
endmodule : epg_gpio_port
`default_nettype wire

// ==== epg_pkg.sv ====
// types for the eight pin gpio port
`default_nettype none
package epg_pkg;
    typedef logic [7:0] epg_byte_t;
    typedef enum logic [1:0] {
        EPG_RD_IDLE,
        EPG_RD_WAIT,
        EPG_RD_DONE
    } epg_rd_state_t;
endpackage : epg_pkg
`default_nettype wire

// ==== epg_sync.sv ====
// two flop synchroniser for the pin inputs
`default_nettype none
module epg_sync #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // idle pins read high because of the pullup
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule : epg_sync
`default_nettype wire

// ==== tb.sv ====
// testbench for the eight pin gpio port
`include "epg_consts.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import epg_pkg::*;
    logic ref_clk, rst, reg_wr, reg_rd, reg_rvalid, alarm_event;
    logic conv_start, conv_done, adc_data_access, fault_input, fault_output;
    logic conversion_trigger_input, data_ready_indicator;
    logic [7:0] reg_addr, pin_in, pin_out, pin_oe, ext_en, ext_val;
    epg_byte_t reg_wdata, reg_rdata;
    int err_total = 0;
    int n_compared = 0;
    epg_gpio_port u_epg_gpio_port (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .alarm_event(alarm_event), .conv_start(conv_start), .conv_done(conv_done),
        .adc_data_access(adc_data_access), .fault_input(fault_input),
        .fault_output(fault_output), .conversion_trigger_input(conversion_trigger_input),
        .data_ready_indicator(data_ready_indicator));
    epg_board u_epg_board (.pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val),
        .pin_level(pin_in));
    // ==========================================
    // clock and tasks
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        // idle edge so the next call never re-raises a strobe in this time step
        tick(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        check("rvalid", {7'h00, reg_rvalid}, 8'h01);
        check("rdata", reg_rdata, exp);
        tick(1);
    endtask : rd
    // order is start, done, access; one cycle pulse then one settle cycle
    task automatic core(input logic [2:0] v);
        {conv_start, conv_done, adc_data_access} = v;
        tick(1);
        {conv_start, conv_done, adc_data_access} = 3'h0;
        tick(1);
    endtask : core
    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    // ==========================================
    // tests
    initial begin
        {rst, reg_wr, reg_rd, alarm_event, conv_start, conv_done, adc_data_access} = 7'h40;
        {reg_addr, reg_wdata, ext_en, ext_val} = 32'h0;
        repeat (8) @(posedge ref_clk);
        #1 rst = 1'b0;
        check("oe_reset", pin_oe, 8'h00);
        rd(`EPG_DATA_OFFSET, 8'hff);
        rd(`EPG_CFG_OFFSET, 8'h00);
        wr(`EPG_DATA_OFFSET, 8'h5a);
        check("oe_drive", pin_oe, 8'ha5);
        check("pin_out", pin_out, 8'h00);
        tick(3);
        rd(`EPG_DATA_OFFSET, 8'h5a);
        ext_en = 8'h40;
        tick(4);
        rd(`EPG_DATA_OFFSET, 8'h1a);
        wr(8'h33, 8'h00);
        rd(8'h33, 8'h00);
        rd(`EPG_DATA_OFFSET, 8'h1a);
        wr(`EPG_CFG_OFFSET, 8'h0f);
        rd(`EPG_CFG_OFFSET, 8'h0f);
        ext_en = 8'h45;
        ext_val = 8'h04;
        tick(4);
        check("fault_in_low", {7'h00, fault_input}, 8'h01);
        check("trig_high", {7'h00, conversion_trigger_input}, 8'h01);
        check("oe_alt", pin_oe & 8'hf5, 8'ha0);
        ext_val = 8'h01;
        tick(4);
        check("fault_in_high", {7'h00, fault_input}, 8'h00);
        check("trig_low", {7'h00, conversion_trigger_input}, 8'h00);
        alarm_event = 1'b1;
        tick(2);
        check("alarm_on", {7'h00, fault_output}, 8'h01);
        check("alarm_pin", {7'h00, pin_oe[1]}, 8'h01);
        alarm_event = 1'b0;
        tick(2);
        check("alarm_off", {7'h00, fault_output}, 8'h00);
        core(3'h2);
        check("ready_set", {7'h00, data_ready_indicator}, 8'h01);
        check("ready_pin", {7'h00, pin_oe[3]}, 8'h01);
        core(3'h1);
        check("ready_access", {7'h00, data_ready_indicator}, 8'h00);
        core(3'h2);
        core(3'h4);
        check("ready_start", {7'h00, data_ready_indicator}, 8'h00);
        core(3'h6);
        check("ready_both", {7'h00, data_ready_indicator}, 8'h01);
        wr(`EPG_CFG_OFFSET, 8'h00);
        ext_val = 8'h00;
        core(3'h2);
        tick(3);
        check("gpio_ready", {5'h00, data_ready_indicator, pin_oe[3], fault_input}, 8'h00);
        // forced reset in mid-run
        ext_en = 8'h00;
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        check("oe_reset2", pin_oe, 8'h00);
        rd(`EPG_DATA_OFFSET, 8'hff);
        rd(`EPG_CFG_OFFSET, 8'h00);
        wrap_up();
    end
    // whole run is under a hundred cycles
    initial begin
        #100us;
        err_total++;
        wrap_up();
    end
endmodule : tb
`default_nettype wire
